/* File: smsr_core_model.sv */
/* Processor core model driving the peripheral register bus.
   Assumes the bench calls access from code running on mclk falling edges. */
`timescale 1ns/100ps
`default_nettype none
module smsr_core_model
    import smsr_pkg::*;
(
    input  wire logic               mclk,  // System clock.
    output var  logic [SMSR_AW-1:0] addr,  // Peripheral address.
    output var  logic               wr_en, // Write strobe.
    output var  logic               rd_en, // Read strobe.
    output var  logic [SMSR_DW-1:0] wdata, // Write data.
    input  wire logic [SMSR_DW-1:0] rdata  // Registered read data.
);
    // The bus starts idle.
    initial
    begin
        addr  = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wdata = '0;
    end
    // One access of one cycle; released data is inverted so stale values never look valid.
    task automatic access(input logic wr, input logic [13:0] a, input logic [15:0] d, output logic [15:0] q);
        @(negedge mclk);
        addr  = a;
        wr_en = wr;
        rd_en = !wr;
        wdata = d;
        @(negedge mclk);
        wr_en = 1'b0;
        rd_en = 1'b0;
        wdata = ~d;
        q     = rdata;
    endtask : access
endmodule : smsr_core_model
`default_nettype wire

/* File: smsr_pkg.sv */
/*
 * Constants and types shared by the system mode and status register pair.
 * Assumes a 16-bit peripheral data bus driven by the processor core.
 */
// Operation
// - Status bit 0 mirrors synchronised shutdown pin, forced low while PWM trip active
// - Status bit 1 set after watchdog timeout
// - Status bit 2 reflects polarity pin level
// - Status bit 3 shows current PWM half
// - Mode register at 0x2015, bits six to four
// - Status register at 0x2016, four bits
// - Mode bit 4 selects second receive pin
// - Mode bit 5 enables UART tie-up
`default_nettype none

package smsr_pkg;

    localparam int          SMSR_AW           = 14;
    localparam int          SMSR_DW           = 16;
    localparam logic [13:0] SMSR_MODE_ADDR    = 14'h2015;
    localparam logic [13:0] SMSR_STAT_ADDR    = 14'h2016;
    localparam int          SMSR_MODE_RXSEL   = 4;
    localparam int          SMSR_MODE_UART    = 5;
    localparam int          SMSR_MODE_DBL     = 6;
    localparam int          SMSR_STAT_TRIP    = 0;
    localparam int          SMSR_STAT_WDOG    = 1;
    localparam int          SMSR_STAT_POL     = 2;
    localparam int          SMSR_STAT_HALF    = 3;
    localparam logic [2:0]  SMSR_MODE_RESET   = 3'h0;
    localparam int          SMSR_SYNC_STAGES  = 2;

    // Mode bits in order double update, uart, receive select.
    typedef struct packed
    {
        logic dbl_update;
        logic async_mode_enable;
        logic receive_pin_select;
    } smsr_mode_t;

    // Serial port one pins as seen from the core side.
    typedef struct packed
    {
        logic rx_data;
        logic rx_frame_sync_one;
    } smsr_sport_t;

endpackage : smsr_pkg

`default_nettype wire

/* File: smsr_regs.sv */
/*
 * System mode control and status registers with serial port one pin steering.
 * Assumes the core presents address, write strobe and read strobe in one cycle,
 * and the watchdog pulses wdog_timeout for one cycle on expiry.
 */
`timescale 1ns/100ps
`default_nettype none

module smsr_regs
    import smsr_pkg::*;
(
    input  wire logic              mclk,                 // System clock, 20 MHz.
    input  wire logic              rst_n,                // Asynchronous reset, active low.
    input  wire logic              wdog_reset_n,         // Low while a watchdog reset is applied.
    input  wire logic [SMSR_AW-1:0] addr,                // Peripheral address.
    input  wire logic              wr_en,                // Write strobe.
    input  wire logic              rd_en,                // Read strobe.
    input  wire logic [SMSR_DW-1:0] wdata,               // Write data.
    output var  logic [SMSR_DW-1:0] rdata,               // Read data, registered.
    input  wire logic              pwm_shutdown_pin,     // Shutdown pin, high when no trip.
    input  wire logic              pwm_trip_active,      // Trip active in the PWM block.
    input  wire logic              pwm_polarity_pin,     // Polarity pin.
    input  wire logic              pwm_half_cycle,       // Current PWM half from the generator.
    input  wire logic              wdog_timeout,         // Watchdog timeout pulse.
    input  wire logic              serial_rx_pin_first,  // First receive pin.
    input  wire logic              serial_rx_pin_second, // Second receive pin.
    input  wire logic              rx_frame_sync_pin,    // External receive frame sync input.
    input  wire logic              software_flag_one,    // Core software flag one.
    output var  smsr_sport_t       sport_in,             // Internal serial port one inputs.
    output var  logic              frame_sync_pin_out,   // Drive for frame-sync/ROM-reset pin.
    output var  logic              frame_sync_pin_oe,    // Output enable of that pin.
    output var  logic              pwm_double_update     // Update mode to the PWM generator.
);

    smsr_mode_t mode_r;
    logic       wdog_seen_r;
    logic       trip_sync;
    logic       pol_sync;
    logic [3:0] status;
    logic       rx_sel;

    smsr_sync #(.RESET_VAL(1'b1)) u_trip_sync
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   (pwm_shutdown_pin),
        .dout  (trip_sync)
    );

    smsr_sync #(.RESET_VAL(1'b0)) u_pol_sync
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   (pwm_polarity_pin),
        .dout  (pol_sync)
    );

    // Mode register write; only bits six to four are stored.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_r <= SMSR_MODE_RESET;
        end
        else if (wr_en && addr == SMSR_MODE_ADDR)
        begin
            mode_r <= wdata[SMSR_MODE_DBL:SMSR_MODE_RXSEL];
        end
    end

    // Watchdog flag survives the watchdog reset it causes; only power-on reset clears it.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wdog_seen_r <= 1'b0;
        end
        else if (wdog_timeout || !wdog_reset_n)
        begin
            wdog_seen_r <= 1'b1;
        end
    end

    // Status word assembly.
    always_comb
    begin
        status                 = 4'h0;
        status[SMSR_STAT_TRIP] = trip_sync && !pwm_trip_active;
        status[SMSR_STAT_WDOG] = wdog_seen_r;
        status[SMSR_STAT_POL]  = pol_sync;
        status[SMSR_STAT_HALF] = pwm_half_cycle;
    end

    // Registered read port; unmapped addresses return zero.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= 16'h0000;
        end
        else if (rd_en && addr == SMSR_MODE_ADDR)
        begin
            rdata <= {9'h000, mode_r, 4'h0};
        end
        else if (rd_en && addr == SMSR_STAT_ADDR)
        begin
            rdata <= {12'h000, status};
        end
        else if (rd_en)
        begin
            rdata <= 16'h0000;
        end
    end

    // Serial port one pin steering.
    always_comb
    begin
        rx_sel = mode_r.receive_pin_select ? serial_rx_pin_second : serial_rx_pin_first;
        sport_in.rx_data           = rx_sel;
        sport_in.rx_frame_sync_one = mode_r.async_mode_enable ? rx_sel : rx_frame_sync_pin;
        frame_sync_pin_out         = mode_r.async_mode_enable ? software_flag_one : 1'b0;
        frame_sync_pin_oe          = mode_r.async_mode_enable;
        pwm_double_update          = mode_r.dbl_update;
    end

    // Mode bit 4 routes the second pin.
    rx_select_a: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_r.receive_pin_select |-> sport_in.rx_data == serial_rx_pin_second)
        else $error("receive select routes wrong pin");

    // With mode bit 4 clear the first pin feeds the port.
    rx_first_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !mode_r.receive_pin_select |-> sport_in.rx_data == serial_rx_pin_first)
        else $error("first receive pin not routed");

    // Asynchronous mode ties data to frame sync and hands the pin to flag one.
    uart_tie_a: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_r.async_mode_enable |-> sport_in.rx_frame_sync_one == sport_in.rx_data
        && frame_sync_pin_out == software_flag_one && frame_sync_pin_oe)
        else $error("uart mode tie-up wrong");

    // Outside asynchronous mode the pin is released and frame sync comes from outside.
    uart_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !mode_r.async_mode_enable |-> !frame_sync_pin_oe && !frame_sync_pin_out
        && sport_in.rx_frame_sync_one == rx_frame_sync_pin)
        else $error("uart tie-up active while off");

    // A mode write reaches the update mode output one cycle later.
    mode_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && addr == SMSR_MODE_ADDR |=> pwm_double_update == $past(wdata[SMSR_MODE_DBL]))
        else $error("mode write not taken");

    // Without a mode write the mode bits hold, so other addresses cannot disturb them.
    mode_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !(wr_en && addr == SMSR_MODE_ADDR) |=> $stable(mode_r))
        else $error("mode register changed without write");

    // Mode reads return the stored bits in their own positions.
    mode_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_en && addr == SMSR_MODE_ADDR |=> rdata == {9'h000, $past(mode_r), 4'h0})
        else $error("mode read wrong");

    // Status reads return the four status bits and zero above.
    stat_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_en && addr == SMSR_STAT_ADDR |=> rdata[3:0] == $past(status) && rdata[15:4] == 12'h000)
        else $error("status read wrong");

    // Reads of any other address return zero.
    unmapped_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_en && addr != SMSR_MODE_ADDR && addr != SMSR_STAT_ADDR |=> rdata == 16'h0000)
        else $error("unmapped read not zero");

    // Read data holds between reads.
    rdata_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !rd_en |=> $stable(rdata))
        else $error("read data changed without read");

    // A timeout pulse leaves the flag set.
    wdog_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wdog_timeout |=> status[SMSR_STAT_WDOG] [*2])
        else $error("watchdog flag not sticky");

    // A watchdog reset also marks the timeout.
    wdog_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !wdog_reset_n |=> status[SMSR_STAT_WDOG])
        else $error("watchdog reset not flagged");

    // With no watchdog event the flag stays clear in normal operation.
    wdog_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !wdog_seen_r && !wdog_timeout && wdog_reset_n |=> !wdog_seen_r)
        else $error("watchdog flag set without event");

    // An active trip forces the shutdown bit low at once.
    trip_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pwm_trip_active |-> !status[SMSR_STAT_TRIP])
        else $error("trip bit high during trip");

    // A low shutdown pin reaches the bit through the synchroniser.
    trip_pin_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !pwm_shutdown_pin [*3] |-> !status[SMSR_STAT_TRIP])
        else $error("trip bit ignores low pin");

    // A high shutdown pin with no trip reads as one.
    trip_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pwm_shutdown_pin [*3] ##0 !pwm_trip_active |-> status[SMSR_STAT_TRIP])
        else $error("trip bit low with pin high");

    // A high polarity pin reaches the bit through the synchroniser.
    pol_pin_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pwm_polarity_pin [*3] |-> status[SMSR_STAT_POL])
        else $error("polarity bit not following pin");

    // A low polarity pin reads as zero.
    pol_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !pwm_polarity_pin [*3] |-> !status[SMSR_STAT_POL])
        else $error("polarity bit not following low pin");

    // A status read shows the half cycle that stood when it was taken.
    half_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_en && addr == SMSR_STAT_ADDR |=> rdata[SMSR_STAT_HALF] == $past(pwm_half_cycle))
        else $error("half cycle bit mismatch");

endmodule : smsr_regs

`default_nettype wire

/* File: smsr_regs_bench.sv */
/* Self-checking bench for the mode and status registers.
   Assumes the core model in its own file; inputs change on falling edges. */
`timescale 1ns/100ps
`default_nettype none
module smsr_regs_bench;
    import smsr_pkg::*;
    logic               mclk = 1'b0;
    logic               rst_n = 1'b0;
    logic               wdog_reset_n = 1'b1;
    logic               wdt = 1'b0;
    logic [7:0]         stim = 8'h01;
    logic [SMSR_AW-1:0] addr;
    logic               wr_en;
    logic               rd_en;
    logic [SMSR_DW-1:0] wdata;
    logic [SMSR_DW-1:0] rdata;
    smsr_sport_t        sport_in;
    logic               fs_out;
    logic               fs_oe;
    logic               dbl;
    int                 checks = 0;
    int                 fail_count = 0;

    // Clock of 50 ns period.
    always #25 mclk = ~mclk;

    smsr_core_model core_u (.mclk(mclk), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata));
    smsr_regs dut_u (.mclk(mclk), .rst_n(rst_n), .wdog_reset_n(wdog_reset_n), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .pwm_shutdown_pin(stim[0]), .pwm_trip_active(stim[1]),
        .pwm_polarity_pin(stim[2]), .pwm_half_cycle(stim[3]), .wdog_timeout(wdt), .serial_rx_pin_first(stim[4]),
        .serial_rx_pin_second(stim[5]), .rx_frame_sync_pin(stim[6]), .software_flag_one(stim[7]),
        .sport_in(sport_in), .frame_sync_pin_out(fs_out), .frame_sync_pin_oe(fs_oe), .pwm_double_update(dbl));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic give_verdict;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    // Cuts a hung run short.
    initial
    begin
        #2ms;
        fail_count++;
        give_verdict();
    end

    // Main sequence: all mode codes first, then random modes, with random pin levels throughout.
    initial
    begin
        logic [15:0] q;
        logic [2:0]  m;
        logic [31:0] seed;
        logic        wd_exp;
        seed   = 32'h35EF;
        wd_exp = 1'b0;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        core_u.access(1'b0, SMSR_MODE_ADDR, 16'h0000, q);
        chk("mode reset", 16'h0000, q);
        for (int i = 0; i < 24; i++)
        begin
            seed = lfsr(seed);
            m    = (i < 8) ? 3'(i) : seed[10:8];
            stim = seed[7:0];
            if (i == 16)
            begin
                @(negedge mclk) wdt = 1'b1;
                @(negedge mclk) wdt = 1'b0;
                wd_exp = 1'b1;
            end
            core_u.access(1'b1, SMSR_MODE_ADDR, (seed[31:16] & 16'hFF8F) | {9'h000, m, 4'h0}, q);
            chk("double update", 16'(m[2]), 16'(dbl));
            chk("receive data", 16'(m[0] ? stim[5] : stim[4]), 16'(sport_in.rx_data));
            chk("frame sync", 16'(m[1] ? (m[0] ? stim[5] : stim[4]) : stim[6]),
                16'(sport_in.rx_frame_sync_one));
            chk("pin drive", {14'h0000, m[1], m[1] & stim[7]}, {14'h0000, fs_oe, fs_out});
            core_u.access(1'b1, SMSR_STAT_ADDR, 16'hFFFF, q);
            core_u.access(1'b0, SMSR_MODE_ADDR, 16'h0000, q);
            chk("mode readback", {9'h000, m, 4'h0}, q);
            core_u.access(1'b0, SMSR_STAT_ADDR, 16'h0000, q);
            chk("status", {12'h000, stim[3], stim[2], wd_exp, stim[0] & ~stim[1]}, q);
        end
        core_u.access(1'b1, 14'h2017, 16'hFFFF, q);
        core_u.access(1'b0, 14'h2017, 16'h0000, q);
        chk("unmapped read", 16'h0000, q);
        core_u.access(1'b0, SMSR_MODE_ADDR, 16'h0000, q);
        chk("mode after unmapped write", {9'h000, m, 4'h0}, q);
        @(negedge mclk) rst_n = 1'b0;
        @(negedge mclk) rst_n = 1'b1;
        core_u.access(1'b0, SMSR_STAT_ADDR, 16'h0000, q);
        chk("watchdog flag cleared", 16'h0000, 16'(q[1]));
        core_u.access(1'b0, SMSR_MODE_ADDR, 16'h0000, q);
        chk("mode after reset", 16'h0000, q);
        @(negedge mclk) wdog_reset_n = 1'b0;
        @(negedge mclk) wdog_reset_n = 1'b1;
        core_u.access(1'b0, SMSR_STAT_ADDR, 16'h0000, q);
        chk("watchdog flag set", 16'h0001, 16'(q[1]));
        give_verdict();
    end
endmodule : smsr_regs_bench
`default_nettype wire

/* File: smsr_sync.sv */
/*
 * Two flip-flop level synchroniser for one pin.
 * Assumes the pin may change at any time relative to mclk.
 */
`timescale 1ns/100ps
`default_nettype none

module smsr_sync
    import smsr_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
)
(
    input  wire logic mclk,  // System clock.
    input  wire logic rst_n, // Asynchronous reset, active low.
    input  wire logic din,   // Raw pin level.
    output var  logic dout   // Synchronised level.
);

    logic meta_r;

    // First stage feeds only the second stage.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= RESET_VAL;
            dout   <= RESET_VAL;
        end
        else
        begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule : smsr_sync

`default_nettype wire
